// ---- wss_map.svh ----
// Register map, field positions and timing counts for the wake and supply status block
// Function
// - Bit 22 shows the live level of the local wake pin and no clear access touches it.
// - The wake pin level bit follows the pin only while the pin is set up as a wake input, otherwise it holds.
// - Bit 20 latches a wake-up caused by the local wake pin until a read-and-clear access.
// - Bit 18 latches a wake-up caused by LIN bus activity until a read-and-clear access.
// - Bit 17 latches a wake-up caused by the internal wake timer until a read-and-clear access.
// - Bit 16 shows live whether the device is in debug mode and cannot be cleared.
// - Bit 15 latches a main regulator undervoltage until a read-and-clear access.
// - Bits 14 to 12 count thermal level 2 events that restarted the main regulator, untouched by clears.
// - The restart count returns to zero by itself after one minute with no further such event.
// - The wake pin is a wake input when its select bit is 0 and a measurement input when it is 1, the default.
`ifndef WSS_MAP_SVH
`define WSS_MAP_SVH

`define WSS_ADDR_W 6
`define WSS_STATUS_OFFSET 6'h31
`define WSS_LOW_BIT 12
`define WSS_BIT_RSVD_23 23
`define WSS_BIT_WAKE_LEVEL 22
`define WSS_BIT_RSVD_21 21
`define WSS_BIT_PIN_WAKE 20
`define WSS_BIT_RSVD_19 19
`define WSS_BIT_LIN_WAKE 18
`define WSS_BIT_TIMER_WAKE 17
`define WSS_BIT_DEBUG 16
`define WSS_BIT_UV 15
`define WSS_BIT_COUNT_HI 14
`define WSS_BIT_COUNT_LO 12
`define WSS_FUNC_SELECT_RESET 1'b1
`define WSS_CLK_HZ 10000000
`define WSS_QUIET_MS 60000
`define WSS_QUIET_CYCLES (`WSS_QUIET_MS * (`WSS_CLK_HZ / 1000))

`endif

// ---- wss_pkg.sv ----
// Types shared by the wake and supply status block
package wss_pkg;
  typedef logic [2:0] wss_count_t;
  typedef logic [11:0] wss_word_t;
  typedef logic [5:0] wss_addr_t;
endpackage

// ---- wss_status.sv ----
// Upper half of the wake and supply status register with latched flags and restart counter
`timescale 1ns/1ns
`include "wss_map.svh"

module wss_status
  import wss_pkg::*;
#(
  parameter int QUIET_CYCLES = `WSS_QUIET_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Status sources
  input wire logic local_wake_pin,
  input wire logic wake_pin_function_select,
  input wire logic wake_evt_pin,
  input wire logic wake_evt_lin,
  input wire logic wake_evt_timer,
  input wire logic debug_mode,
  input wire logic main_regulator_undervoltage,
  input wire logic thermal_shutdown_level2,
  // Register access from the serial port
  input wire logic rd_req,
  input wire wss_addr_t rd_addr,
  input wire logic rd_clear,
  output wss_word_t rd_data,
  output logic rd_valid
);

  localparam int QW = $clog2(QUIET_CYCLES + 1);

  // Quiet timer needs room for at least two counts
  if (QUIET_CYCLES < 2) begin : g_quiet_bad
    $error("QUIET_CYCLES must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_r;
  logic rst_n_r;

  // Two stages so release never lands mid-setup
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access decode
  logic hit;
  logic rc_hit;
  assign hit = rd_req && (rd_addr == `WSS_STATUS_OFFSET);
  assign rc_hit = hit && rd_clear;

  logic wake_level_r;
  logic pin_wake_r;
  logic lin_wake_r;
  logic timer_wake_r;
  logic uv_r;
  wss_count_t count_r;
  logic [QW-1:0] quiet_r;

  ////////////////////////////////////////////////////////////////////////////
  // Wake pin level
  // select 0 means wake input; hold otherwise
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wake_level_r <= 1'b0;
    end else if (!wake_pin_function_select) begin
      // live copy, clears never reach it
      wake_level_r <= local_wake_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched flags, set wins over read-and-clear
  // clear only after contents sampled, events kept
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_wake_r <= 1'b0;
      lin_wake_r <= 1'b0;
      timer_wake_r <= 1'b0;
      uv_r <= 1'b0;
    end else begin
      pin_wake_r <= wake_evt_pin || (pin_wake_r && !rc_hit);
      lin_wake_r <= wake_evt_lin || (lin_wake_r && !rc_hit);
      timer_wake_r <= wake_evt_timer || (timer_wake_r && !rc_hit);
      uv_r <= main_regulator_undervoltage || (uv_r && !rc_hit);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Restart counter and quiet timer
  // Saturates at seven so a burst cannot wrap back to a small count
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      count_r <= '0;
      quiet_r <= '0;
    end else if (thermal_shutdown_level2) begin
      if (count_r != 3'h7) begin
        count_r <= count_r + 3'h1;
      end
      quiet_r <= '0;
    end else if (count_r != '0) begin
      // self clear after a quiet minute
      if (quiet_r == QW'(QUIET_CYCLES - 1)) begin
        count_r <= '0;
        quiet_r <= '0;
      end else begin
        quiet_r <= quiet_r + QW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the request
  wss_word_t word;

  always_comb begin
    word = '0;
    word[`WSS_BIT_WAKE_LEVEL - `WSS_LOW_BIT] = wake_level_r;
    word[`WSS_BIT_PIN_WAKE - `WSS_LOW_BIT] = pin_wake_r;
    word[`WSS_BIT_LIN_WAKE - `WSS_LOW_BIT] = lin_wake_r;
    word[`WSS_BIT_TIMER_WAKE - `WSS_LOW_BIT] = timer_wake_r;
    word[`WSS_BIT_DEBUG - `WSS_LOW_BIT] = debug_mode;
    word[`WSS_BIT_UV - `WSS_LOW_BIT] = uv_r;
    word[`WSS_BIT_COUNT_HI - `WSS_LOW_BIT:`WSS_BIT_COUNT_LO - `WSS_LOW_BIT] = count_r;
  end

  // Unmapped address answers with zero data
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_req;
      if (rd_req) begin
        rd_data <= hit ? word : '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_r);

  localparam int IL = `WSS_BIT_WAKE_LEVEL - `WSS_LOW_BIT;
  localparam int IP = `WSS_BIT_PIN_WAKE - `WSS_LOW_BIT;
  localparam int ID = `WSS_BIT_DEBUG - `WSS_LOW_BIT;

  wake_level_track_a: assert property (!wake_pin_function_select ##1 rd_req && hit |=>
    rd_data[IL] == $past(local_wake_pin, 2)) else $error("wake level not tracking pin");
  wake_level_hold_a: assert property (wake_pin_function_select |=> $stable(wake_level_r))
    else $error("wake level moved while pin in measurement mode");
  pin_wake_set_a: assert property (wake_evt_pin ##1 hit |=> rd_data[IP])
    else $error("pin wake flag not reported");
  // LIN source: set on event, held until a clear
  lin_wake_set_a: assert property (wake_evt_lin |=> lin_wake_r)
    else $error("LIN wake flag not set");
  lin_wake_hold_a: assert property (lin_wake_r && !rc_hit |=> lin_wake_r)
    else $error("LIN wake flag lost before clear");
  timer_wake_hold_a: assert property (timer_wake_r && !rc_hit |=> timer_wake_r)
    else $error("timer wake flag dropped without clear");
  debug_live_a: assert property (hit |=> rd_data[ID] == $past(debug_mode))
    else $error("debug bit not live");
  uv_set_a: assert property (main_regulator_undervoltage |=> uv_r [*2] or (uv_r ##1 $past(rc_hit)))
    else $error("undervoltage flag not latched");
  count_step_a: assert property (thermal_shutdown_level2 && count_r != 3'h7 |=> count_r == $past(count_r) + 3'h1)
    else $error("restart count did not step");
  count_quiet_a: assert property (count_r != '0 && !thermal_shutdown_level2 && quiet_r == QW'(QUIET_CYCLES - 1)
    |=> count_r == '0) else $error("restart count not cleared after quiet time");
  reserved_zero_a: assert property (rd_valid |-> rd_data[11] == 1'b0 && rd_data[9] == 1'b0 && rd_data[7] == 1'b0)
    else $error("reserved bit read as one");
  clear_keeps_a: assert property (rc_hit && wake_evt_pin |=> pin_wake_r)
    else $error("event lost during read and clear");
  clear_flags_a: assert property (rc_hit && !wake_evt_lin && !wake_evt_timer |=> !lin_wake_r && !timer_wake_r)
    else $error("flags not cleared");

  // Further latch, wake level and counter checks
  pin_wake_latch_a: assert property (wake_evt_pin |=> pin_wake_r)
    else $error("pin wake flag not set");
  timer_wake_set_a: assert property (wake_evt_timer |=> timer_wake_r)
    else $error("timer wake flag not set");
  uv_hold_a: assert property (uv_r && !rc_hit |=> uv_r)
    else $error("undervoltage flag dropped without clear");
  wake_level_live_a: assert property (!wake_pin_function_select |=> wake_level_r == $past(local_wake_pin))
    else $error("wake level not following pin");
  count_saturate_a: assert property (thermal_shutdown_level2 && count_r == 3'h7 |=> count_r == 3'h7)
    else $error("restart count wrapped");
  count_clear_ignored_a: assert property (rc_hit && !thermal_shutdown_level2
    && quiet_r != QW'(QUIET_CYCLES - 1) |=> $stable(count_r))
    else $error("restart count moved on a clear");
  // Read port timing
  valid_source_a: assert property (rd_valid |-> $past(rd_req))
    else $error("answer without request");
  data_hold_a: assert property (!rd_req |=> $stable(rd_data))
    else $error("read data moved without request");
  unmapped_zero_a: assert property (rd_req && !hit |=> rd_data == '0)
    else $error("unmapped read not zero");

  // Main scenarios reached by the bench
  read_clear_c: cover property (pin_wake_r ##1 rc_hit ##1 !pin_wake_r);
  count_full_c: cover property (count_r == 3'h7);
  quiet_clear_c: cover property (count_r != '0 ##1 count_r == '0);
  debug_read_c: cover property (hit && debug_mode);
  clear_event_c: cover property (rc_hit && wake_evt_pin);

endmodule

// ---- wss_host_model.sv ----
// Host model that reads the status register over the serial port
`timescale 1ns/1ns
module wss_host_model
  import wss_pkg::*;
(
  // Clock
  input wire logic clk,
  // Request lines
  output logic rd_req,
  output wss_addr_t rd_addr,
  output logic rd_clear,
  // Answer lines
  input wire wss_word_t rd_data,
  input wire logic rd_valid
);
  // Idle bus at time zero
  initial begin
    rd_req = 1'b0;
    rd_addr = 6'h00;
    rd_clear = 1'b0;
  end
  //////////////////////////////
  // one read per call
  // Called at a falling edge; released lines are inverted so stale values never look valid
  task automatic read(input wss_addr_t a, input logic c, output wss_word_t data, output logic ok);
    ok = 1'b0;
    data = 12'h000;
    rd_req = 1'b1;
    rd_addr = a;
    rd_clear = c;
    @(posedge clk);
    // Answer stands for the cycle after the taking edge, so look at the next falling edge
    @(negedge clk);
    rd_req = 1'b0;
    rd_addr = ~a;
    rd_clear = ~c;
    // Bounded wait so a silent block cannot hang the run
    for (int n = 0; n < 4 && !ok; n++) begin
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        data = rd_data;
      end else begin
        @(negedge clk);
      end
    end
    @(negedge clk);
  endtask
endmodule

// ---- wake_and_supply_status_upper_tb_top.sv ----
// Self-checking bench for the upper wake and supply status bits
`timescale 1ns/1ns
module wake_and_supply_status_upper_tb_top import wss_pkg::*; ;
  typedef struct {logic [6:0] in; wss_word_t exp;} wss_row_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic sel = 1'b1, pin = 1'b0, ep = 1'b0, el = 1'b0, et = 1'b0, dbg = 1'b0, uv = 1'b0, tsd = 1'b0;
  logic rd_req, rd_clear, rd_valid, ok;
  wss_addr_t rd_addr;
  wss_word_t rd_data, d;
  int fails = 0, cmp_count = 0;
  // Inputs as {select, pin, pin wake, lin wake, timer wake, debug, undervoltage}
  wss_row_t rows[5] = '{'{7'h30, 12'h500}, '{7'h48, 12'h440}, '{7'h06, 12'h030}, '{7'h01, 12'h008},
    '{7'h62, 12'h010}};
  // 10 MHz clock
  always #50 clk = ~clk;
  //////////////////////////////
  // Short quiet time keeps the run small
  wss_status #(.QUIET_CYCLES(20)) dut_u (.clk(clk), .arst_n(arst_n), .local_wake_pin(pin),
    .wake_pin_function_select(sel), .wake_evt_pin(ep), .wake_evt_lin(el), .wake_evt_timer(et),
    .debug_mode(dbg), .main_regulator_undervoltage(uv), .thermal_shutdown_level2(tsd), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_clear(rd_clear), .rd_data(rd_data), .rd_valid(rd_valid));
  wss_host_model host_u (.clk(clk), .rd_req(rd_req), .rd_addr(rd_addr), .rd_clear(rd_clear),
    .rd_data(rd_data), .rd_valid(rd_valid));
  //////////////////////////////
  // Verdict and end of run
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Read through the host and compare the word
  task automatic rd(input wss_addr_t a, input logic c, input string name, input wss_word_t exp);
    host_u.read(a, c, d, ok);
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected %s expected answer seen none", name);
      wrap_up();
    end else begin
      cmp_count++;
      if (d !== exp) begin
        fails++;
        $display("unexpected %s expected %h seen %h", name, exp, d);
      end
    end
  endtask
  //////////////////////////////
  // Table of sources, then the awkward cases
  initial begin
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    foreach (rows[i]) begin
      {sel, pin, ep, el, et, dbg, uv} = rows[i].in;
      @(negedge clk);
      {ep, el, et, uv} = 4'h0;
      rd(6'h31, 1'b1, "row word", rows[i].exp);
    end
    dbg = 1'b0;
    ep = 1'b1;
    @(negedge clk);
    ep = 1'b0;
    rd(6'h32, 1'b1, "unmapped", 12'h000);
    rd(6'h31, 1'b0, "plain read", 12'h100);
    // Event lands on the same edge as the clear
    fork
      rd(6'h31, 1'b1, "clear with event", 12'h100);
      begin
        {ep, el} = 2'h3;
        @(negedge clk);
        {ep, el} = 2'h0;
      end
    join
    rd(6'h31, 1'b1, "event kept", 12'h140);
    tsd = 1'b1;
    repeat (8) @(negedge clk);
    tsd = 1'b0;
    rd(6'h31, 1'b1, "count saturated", 12'h007);
    rd(6'h31, 1'b1, "count kept", 12'h007);
    repeat (25) @(negedge clk);
    rd(6'h31, 1'b1, "count quiet", 12'h000);
    // Reset in mid-run wipes latched flags
    uv = 1'b1;
    @(negedge clk);
    arst_n = 1'b0;
    uv = 1'b0;
    @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    rd(6'h31, 1'b1, "after reset", 12'h000);
    wrap_up();
  end
endmodule
